/* nvm_access.sv */
// Nonvolatile memory access top: control register, sequencer, AHB-Lite slave
`timescale 1ns/100ps
module nvm_access import nvm_pkg::*; #(
	parameter logic [11:0] PART_ID = 12'h5a3, // Arbitrary value
	parameter logic [3:0] SILICON_REV = 4'h2 // Arbitrary value
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_clk_en,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic i_hready,
	input wire logic [31:0] i_hwdata,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic [15:0] i_status_word,
	output logic [4:0] o_reg_addr,
	input wire logic [15:0] i_reg_rdata,
	output logic o_load_we,
	output logic [4:0] o_load_addr,
	output logic [15:0] o_load_data,
	output logic o_busy,
	output logic o_irq
);
	typedef struct packed {
		nvm_state_t fsm;
		logic [4:0] ctrl_addr;
		logic [4:0] walk;
		logic [2:0] stat;
		logic [2:0] mask;
		logic [31:0] rdata;
		logic hresp;
		logic irq;
		logic busy;
		logic [4:0] reg_addr;
		logic load_we;
		logic [4:0] load_addr;
		logic [15:0] load_data;
	} nvm_top_st_t;

	localparam nvm_top_st_t TOP_RESET = '{fsm: ST_IDLE, ctrl_addr: CTRL_RESET[ADR_MSB:ADR_LSB],
		walk: 5'h00, stat: IRQ_RESET, mask: IRQ_RESET, rdata: 32'h0000_0000,
		hresp: 1'b0, irq: 1'b0, busy: 1'b0, reg_addr: 5'h00, load_we: 1'b0,
		load_addr: 5'h00, load_data: 16'h0000};

	nvm_top_st_t s;
	nvm_top_st_t next_s;
	logic bus_wr;
	logic bus_rd;
	logic [7:0] bus_addr;
	logic wr_ctrl;
	logic keyed;
	logic [4:0] cmd_addr;
	logic [4:0] a_addr;
	logic [15:0] a_data;
	logic [3:0] a_count;
	logic [15:0] b_data;
	logic [3:0] b_count;
	logic mem_we;
	logic [15:0] mem_wdata;
	logic [2:0] events;
	logic [2:0] shown_count;

	////////////////////////////////////////////////////////////////////////////////
	// Bus front end and memory array
	nvm_ahb u_ahb (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_clk_en(i_clk_en),
		.i_hsel(i_hsel),
		.i_haddr(i_haddr),
		.i_htrans(i_htrans),
		.i_hwrite(i_hwrite),
		.i_hready(i_hready),
		.o_hreadyout(o_hreadyout),
		.o_wr(bus_wr),
		.o_rd(bus_rd),
		.o_addr(bus_addr)
	);

	nvm_store u_store (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_clk_en(i_clk_en),
		.i_wr_en(mem_we),
		.i_wr_addr(s.reg_addr),
		.i_wr_data(mem_wdata),
		.i_a_addr(a_addr),
		.o_a_data(a_data),
		.o_a_count(a_count),
		.i_b_addr(s.walk),
		.o_b_data(b_data),
		.o_b_count(b_count)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Command decode; hsize is ignored since only whole words are mapped
	assign wr_ctrl = bus_wr && bus_addr == ADDR_CTRL;
	assign keyed = i_hwdata[KEY_MSB:KEY_LSB] == CMD_KEY;
	assign cmd_addr = i_hwdata[ADR_MSB:ADR_LSB];
	// Port A follows the incoming command, otherwise the selected address
	assign a_addr = wr_ctrl ? cmd_addr : s.ctrl_addr;
	// The store captures the register one cycle after presenting its address
	assign mem_we = s.fsm == ST_STORE;
	assign mem_wdata = i_reg_rdata;
	// Three bits cannot show eight, so an exhausted location reads as seven
	assign shown_count = a_count[3] ? 3'h7 : a_count[2:0];

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer, register file and interrupt logic
	always_comb begin
		next_s = s;
		next_s.load_we = 1'b0;
		next_s.hresp = 1'b0;
		events = 3'h0;
		unique case (s.fsm)
			ST_IDLE: begin
				// Commands arriving while busy are dropped, so only idle decodes
				if (wr_ctrl && !keyed) begin
					events[IRQ_KEY_BAD] = 1'b1;
				end else if (wr_ctrl) begin
					next_s.ctrl_addr = cmd_addr;
					if (i_hwdata[GLOAD_BIT]) begin
						next_s.fsm = ST_GLOAD;
						next_s.walk = 5'h00;
					end else if (i_hwdata[STORE_BIT]) begin
						if (a_count != MAX_PROGRAMS) begin
							next_s.fsm = ST_STORE;
							next_s.reg_addr = cmd_addr;
						end
					end else if (i_hwdata[SLOAD_BIT]) begin
						next_s.load_we = 1'b1;
						next_s.load_addr = cmd_addr;
						next_s.load_data = a_data;
						events[IRQ_LOAD_DONE] = 1'b1;
					end
				end
			end
			ST_STORE: begin
				next_s.fsm = ST_IDLE;
				events[IRQ_STORE_DONE] = 1'b1;
			end
			ST_GLOAD: begin
				// Locations never stored keep their present register value
				if (b_count != 4'h0) begin
					next_s.load_we = 1'b1;
					next_s.load_addr = s.walk;
					next_s.load_data = b_data;
				end
				next_s.walk = s.walk + 5'h01;
				if (s.walk == LAST_LOC) begin
					next_s.fsm = ST_IDLE;
					events[IRQ_LOAD_DONE] = 1'b1;
				end
			end
		endcase
		next_s.busy = next_s.fsm != ST_IDLE;
		// Read data are built in the wait cycle; unmapped reads give zero
		if (bus_rd) begin
			unique case (bus_addr)
				ADDR_ID: next_s.rdata = {16'h0000, PART_ID, SILICON_REV};
				ADDR_CTRL: next_s.rdata = {16'h0000, shown_count,
					i_status_word[STATUS_CRPT_BIT], 4'h0, s.ctrl_addr, 3'h0};
				ADDR_IRQ_STAT: next_s.rdata = {29'h0, s.stat};
				ADDR_IRQ_MASK: next_s.rdata = {29'h0, s.mask};
				default: next_s.rdata = 32'h0000_0000;
			endcase
		end
		// Writes to the identification register and unmapped addresses fall through
		if (bus_wr && bus_addr == ADDR_IRQ_STAT) begin
			next_s.stat = s.stat & ~i_hwdata[2:0];
		end
		if (bus_wr && bus_addr == ADDR_IRQ_MASK) begin
			next_s.mask = i_hwdata[2:0];
		end
		// New events win over a clear in the same cycle
		next_s.stat = next_s.stat | events;
		next_s.irq = |(next_s.stat & next_s.mask);
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			s <= TOP_RESET;
		end else if (i_clk_en) begin
			s <= next_s;
		end
	end

	// Outputs straight from the state flops
	assign o_hrdata = s.rdata;
	assign o_hresp = s.hresp;
	assign o_reg_addr = s.reg_addr;
	assign o_load_we = s.load_we;
	assign o_load_addr = s.load_addr;
	assign o_load_data = s.load_data;
	assign o_busy = s.busy;
	assign o_irq = s.irq;

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the control path
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_reset);

	a_id_part: assert property (
		bus_rd && bus_addr == ADDR_ID && i_clk_en |=> o_hrdata[15:4] == PART_ID)
		else $error("part identifier read back wrong");

	a_id_rev: assert property (
		bus_rd && bus_addr == ADDR_ID && i_clk_en |=> o_hrdata[3:0] == SILICON_REV && o_hreadyout)
		else $error("silicon revision read back wrong");

	a_ctrl_reset: assert property (@(posedge i_clk_sys) disable iff (1'b0)
		$fell(i_reset) |-> s.ctrl_addr == 5'h00 && s.fsm == ST_IDLE)
		else $error("control register not zero after reset");

	a_addr_take: assert property (
		wr_ctrl && keyed && s.fsm == ST_IDLE && i_clk_en |=> s.ctrl_addr == $past(cmd_addr))
		else $error("address field not captured");

	a_count_show: assert property (
		bus_rd && bus_addr == ADDR_CTRL && i_clk_en
		|=> o_hrdata[15:13] == ($past(a_count) > 4'h7 ? 3'h7 : $past(a_count[2:0])))
		else $error("program count read back wrong");

	a_store_limit: assert property (
		wr_ctrl && keyed && !i_hwdata[GLOAD_BIT] && i_hwdata[STORE_BIT]
		&& a_count == MAX_PROGRAMS && s.fsm == ST_IDLE && i_clk_en |=> s.fsm == ST_IDLE)
		else $error("store to exhausted location was not ignored");

	a_crpt_mirror: assert property (
		bus_rd && bus_addr == ADDR_CTRL && i_clk_en
		|=> o_hrdata[12] == $past(i_status_word[STATUS_CRPT_BIT]))
		else $error("memory corrupt bit does not mirror status");

	a_gload_walk: assert property (
		s.fsm == ST_GLOAD && s.walk == LAST_LOC && i_clk_en |=> s.fsm == ST_IDLE && !o_busy)
		else $error("general load did not end after the last location");

	a_store_seq: assert property (
		wr_ctrl && keyed && !i_hwdata[GLOAD_BIT] && i_hwdata[STORE_BIT]
		&& a_count < MAX_PROGRAMS && s.fsm == ST_IDLE && i_clk_en
		|=> s.fsm == ST_STORE && o_reg_addr == $past(cmd_addr) && o_busy)
		else $error("store did not start on the addressed register");

	a_single_load: assert property (
		wr_ctrl && keyed && i_hwdata[2:0] == 3'h1 && s.fsm == ST_IDLE && i_clk_en
		|=> o_load_we && o_load_addr == $past(cmd_addr) && o_load_data == $past(a_data))
		else $error("single load wrote wrong register or data");

	a_key_gate: assert property (
		wr_ctrl && !keyed && s.fsm == ST_IDLE && i_clk_en |=> s.fsm == ST_IDLE && !o_load_we)
		else $error("unkeyed write started an operation");

	a_irq_level: assert property (
		i_clk_en |=> o_irq == |(s.stat & s.mask))
		else $error("interrupt output disagrees with status and mask");

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the sequencer and the interrupt bookkeeping
	a_store_done: assert property (
		s.fsm == ST_STORE && i_clk_en
		|=> s.fsm == ST_IDLE && s.stat[IRQ_STORE_DONE] && !o_busy)
		else $error("store did not finish in one cycle");

	// Port A shows the stored word next cycle unless a new command moved it
	a_store_data: assert property (
		s.fsm == ST_STORE && !wr_ctrl && i_clk_en
		|=> wr_ctrl || (a_data == $past(i_reg_rdata) && a_count == $past(a_count) + 4'h1))
		else $error("store did not capture the register contents");

	a_load_event: assert property (
		wr_ctrl && keyed && i_hwdata[2:0] == 3'h1 && s.fsm == ST_IDLE && i_clk_en
		|=> s.stat[IRQ_LOAD_DONE])
		else $error("single load raised no load-done event");

	a_gload_start: assert property (
		wr_ctrl && keyed && i_hwdata[GLOAD_BIT] && s.fsm == ST_IDLE && i_clk_en
		|=> s.fsm == ST_GLOAD && s.walk == 5'h00 && o_busy)
		else $error("general load did not start at the first location");

	// A walk step over a never-stored location must leave its register alone
	a_gload_skip: assert property (
		s.fsm == ST_GLOAD && b_count == 4'h0 && i_clk_en |=> !o_load_we)
		else $error("general load wrote a never-stored register");

	a_gload_copy: assert property (
		s.fsm == ST_GLOAD && b_count != 4'h0 && i_clk_en
		|=> o_load_we && o_load_addr == $past(s.walk) && o_load_data == $past(b_data))
		else $error("general load wrote wrong register or data");

	a_badkey_event: assert property (
		wr_ctrl && !keyed && s.fsm == ST_IDLE && i_clk_en |=> s.stat[IRQ_KEY_BAD])
		else $error("wrong key raised no event");

	// Commands that arrive mid-operation are dropped whole, address field too
	a_busy_ignore: assert property (
		wr_ctrl && s.fsm != ST_IDLE && i_clk_en |=> s.ctrl_addr == $past(s.ctrl_addr))
		else $error("command accepted while busy");

	// A clear written in the cycle of an event must not swallow it
	a_irq_set_wins: assert property (
		events != 3'h0 && i_clk_en |=> (s.stat & $past(events)) == $past(events))
		else $error("interrupt event lost to a clear");

	a_mask_write: assert property (
		bus_wr && bus_addr == ADDR_IRQ_MASK && i_clk_en
		|=> s.mask == $past(i_hwdata[2:0]))
		else $error("interrupt mask write did not land");
endmodule // nvm_access

/* nvm_pkg.sv */
// Constants, types and register map of the nonvolatile memory access block
// What this block does
// - Identification register shows a fixed 12-bit part identifier in bits 15..4, read only.
// - Identification register shows a fixed 4-bit silicon revision in bits 3..0.
// - Memory control register sits at register address 2Ah and resets to all zeros.
// - Control bits 7..3 carry the target register address, register map numbering.
// - Control read bits 15..13 report how often the addressed location was programmed, eight showing as seven.
// - Each location takes at most eight stores; further stores are silently ignored.
// - Control bit 12 reads as a mirror of status register bit 8.
// - Keyed write with bit 2 reloads every register whose location was ever stored from memory, address ignored.
// - Keyed write with bit 1 stores the addressed register's contents into memory.
// - Keyed write with bit 0 loads the addressed register from memory.
package nvm_pkg;
	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_ID = 8'h1f;
	localparam logic [7:0] IDX_CTRL = 8'h2a;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h30;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
	localparam logic [7:0] ADDR_ID = {IDX_ID[5:0], 2'b00};
	localparam logic [7:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'b00};
	localparam logic [7:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT[5:0], 2'b00};
	localparam logic [7:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK[5:0], 2'b00};
	// Control word layout
	localparam logic [7:0] CMD_KEY = 8'h6a;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam int KEY_MSB = 15;
	localparam int KEY_LSB = 8;
	localparam int CNT_MSB = 15;
	localparam int CNT_LSB = 13;
	localparam int CRPT_BIT = 12;
	localparam int ADR_MSB = 7;
	localparam int ADR_LSB = 3;
	localparam int GLOAD_BIT = 2;
	localparam int STORE_BIT = 1;
	localparam int SLOAD_BIT = 0;
	localparam int STATUS_CRPT_BIT = 8;
	// Memory geometry
	localparam int NVM_LOCS = 32;
	localparam int NVM_WIDTH = 16;
	localparam logic [3:0] MAX_PROGRAMS = 4'h8;
	localparam logic [4:0] LAST_LOC = 5'h1f;
	// Interrupt status bits
	localparam int IRQ_STORE_DONE = 0;
	localparam int IRQ_LOAD_DONE = 1;
	localparam int IRQ_KEY_BAD = 2;
	localparam logic [2:0] IRQ_RESET = 3'h0;
	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_STORE = 3'b010,
		ST_GLOAD = 3'b100
	} nvm_state_t;
endpackage

/* nvm_store.sv */
// Nonvolatile memory array with per-location program counters
`timescale 1ns/100ps
module nvm_store import nvm_pkg::*; (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_clk_en,
	input wire logic i_wr_en,
	input wire logic [4:0] i_wr_addr,
	input wire logic [15:0] i_wr_data,
	input wire logic [4:0] i_a_addr,
	output logic [15:0] o_a_data,
	output logic [3:0] o_a_count,
	input wire logic [4:0] i_b_addr,
	output logic [15:0] o_b_data,
	output logic [3:0] o_b_count
);
	typedef struct packed {
		logic [NVM_LOCS-1:0][NVM_WIDTH-1:0] mem;
		logic [NVM_LOCS-1:0][3:0] cnt;
	} nvm_store_st_t;

	nvm_store_st_t s;
	nvm_store_st_t next_s;

	////////////////////////////////////////////////////////////////////////////////
	// Write stores the word and bumps the counter; the caller enforces the limit
	always_comb begin
		next_s = s;
		if (i_wr_en) begin
			next_s.mem[i_wr_addr] = i_wr_data;
			next_s.cnt[i_wr_addr] = s.cnt[i_wr_addr] + 4'h1;
		end
	end

	// Two asynchronous read ports, one for commands and one for the reload walk
	assign o_a_data = s.mem[i_a_addr];
	assign o_a_count = s.cnt[i_a_addr];
	assign o_b_data = s.mem[i_b_addr];
	assign o_b_count = s.cnt[i_b_addr];

	// Reset stands in for a freshly erased part
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			s <= '0;
		end else if (i_clk_en) begin
			s <= next_s;
		end
	end

	a_count_ceiling: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		i_wr_en && i_clk_en |-> o_a_count <= MAX_PROGRAMS || i_a_addr != i_wr_addr)
		else $error("program counter passed its ceiling");
endmodule // nvm_store

/* nvm_ahb.sv */
// AHB-Lite slave front end: captures address phases, one wait state on reads
`timescale 1ns/100ps
module nvm_ahb import nvm_pkg::*; (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_clk_en,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_wr,
	output logic o_rd,
	output logic [7:0] o_addr
);
	typedef struct packed {
		logic wr;
		logic rd;
		logic ready;
		logic [7:0] addr;
	} nvm_ahb_st_t;

	nvm_ahb_st_t s;
	nvm_ahb_st_t next_s;
	logic take;

	////////////////////////////////////////////////////////////////////////////////
	// Any NONSEQ or SEQ is taken; the read waits a cycle so data leave a flop
	assign take = i_hsel && i_htrans[1] && i_hready;

	always_comb begin
		next_s = s;
		next_s.wr = 1'b0;
		next_s.rd = 1'b0;
		next_s.ready = 1'b1;
		if (take) begin
			next_s.addr = i_haddr[7:0];
			next_s.wr = i_hwrite;
			next_s.rd = !i_hwrite;
			next_s.ready = i_hwrite;
		end
	end

	assign o_hreadyout = s.ready;
	assign o_wr = s.wr;
	assign o_rd = s.rd;
	assign o_addr = s.addr;

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			s <= '{wr: 1'b0, rd: 1'b0, ready: 1'b1, addr: 8'h00};
		end else if (i_clk_en) begin
			s <= next_s;
		end
	end

	a_read_wait: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		o_rd |-> !o_hreadyout ##1 (o_hreadyout || !i_clk_en))
		else $error("read data phase did not last exactly two cycles");
endmodule // nvm_ahb

/* nvm_regfile_model.sv */
// Behavioural model of the device register file behind the memory access block
`timescale 1ns/100ps
module nvm_regfile_model import nvm_pkg::*; (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic [4:0] i_reg_addr,
	output logic [15:0] o_reg_rdata,
	input wire logic i_load_we,
	input wire logic [4:0] i_load_addr,
	input wire logic [15:0] i_load_data
);
	logic [15:0] regs [0:31];

	//////////////////////////////////////////////////////////////////////////
	// Contents shown without delay, since the store path samples them in one cycle
	assign o_reg_rdata = regs[i_reg_addr];

	// Reset fills a pattern that tells every register apart from erased memory
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			for (int i = 0; i < 32; i++) begin
				regs[i] <= 16'h3c00 | 16'(i);
			end
		end else if (i_load_we) begin
			regs[i_load_addr] <= i_load_data;
		end
	end
endmodule // nvm_regfile_model

/* nvm_access_tb.sv */
// Self-checking testbench of the nonvolatile memory access block
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
	$display("MISMATCH at %0t: got %h expected %h", $time, (a), (e)); end end
module nvm_access_tb import nvm_pkg::*;;
	localparam logic [11:0] PID = 12'h3b7; // Arbitrary value
	localparam logic [3:0] REV = 4'h6; // Arbitrary value
	logic clk, rst, ce, hsel, hwrite, hrdy, hresp, lwe, busy, irq;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans;
	logic [15:0] status, reg_rdata, ldata;
	logic [4:0] reg_addr, laddr;
	logic [20:0] lq [$];
	int err_count = 0;
	int tests_run = 0;
	int k;

	//////////////////////////////////////////////////////////////////////////
	nvm_access #(.PART_ID(PID), .SILICON_REV(REV)) u_nvm_access (
		.i_clk_sys(clk), .i_reset(rst), .i_clk_en(ce), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hready(hrdy), .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hrdy),
		.o_hresp(hresp), .i_status_word(status), .o_reg_addr(reg_addr),
		.i_reg_rdata(reg_rdata), .o_load_we(lwe), .o_load_addr(laddr),
		.o_load_data(ldata), .o_busy(busy), .o_irq(irq));
	nvm_regfile_model u_nvm_regfile_model (
		.i_clk_sys(clk), .i_reset(rst), .i_reg_addr(reg_addr), .o_reg_rdata(reg_rdata),
		.i_load_we(lwe), .i_load_addr(laddr), .i_load_data(ldata));

	//////////////////////////////////////////////////////////////////////////
	// Clock of 4 ns
	initial clk = 1'b0;
	always #2 clk = ~clk;

	// Every load pulse is logged as address and data
	always @(posedge clk) begin
		if (lwe === 1'b1) begin
			lq.push_back({laddr, ldata});
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// The master waits as long as the slave asks; only the watchdog ends a stuck wait
	task automatic wait_rdy();
		do begin
			@(posedge clk);
		end while (hrdy !== 1'b1);
	endtask

	task automatic ahb_wr(input logic [7:0] a, input logic [15:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= 1'b1;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0, d};
		wait_rdy();
	endtask

	task automatic ahb_rd(input logic [7:0] a, output logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= 1'b0;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		wait_rdy();
		d = hrdata;
	endtask

	// Expected control read; a count of eight cannot show in three bits
	function automatic logic [31:0] ctl(int c, logic cr, logic [4:0] a);
		return {16'h0, 3'((c > 7) ? 7 : c), cr, 4'h0, a, 3'b000};
	endfunction

	function automatic logic [15:0] cmd(logic [4:0] a, logic [2:0] op);
		return {CMD_KEY, a, op};
	endfunction

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		give_verdict();
	end

	//////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		status = 16'h0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// Identification is fixed and ignores writes
		ahb_rd(ADDR_ID, r);
		`CHK(r, {16'h0, PID, REV})
		ahb_wr(ADDR_ID, 16'h0);
		ahb_rd(ADDR_ID, r);
		`CHK(r, {16'h0, PID, REV})
		ahb_rd(ADDR_CTRL, r);
		`CHK(r, 32'h0)
		ahb_rd(8'h10, r);
		`CHK(r, 32'h0)
		`CHK(hresp, 1'b0)
		// Wrong key: nothing starts, only the bad key event
		ahb_wr(ADDR_CTRL, {8'h6b, 5'd5, 3'b010});
		ahb_rd(ADDR_CTRL, r);
		`CHK(r, 32'h0)
		ahb_rd(ADDR_IRQ_STAT, r);
		`CHK(r, 32'h4)
		`CHK(irq, 1'b0)
		ahb_wr(ADDR_IRQ_MASK, 16'h7);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b1)
		ahb_wr(ADDR_IRQ_STAT, 16'h7);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		// Nine stores to one place: the ninth must be silent
		status <= 16'h0100;
		for (k = 1; k <= 9; k++) begin
			ahb_wr(ADDR_IRQ_STAT, 16'h7);
			ahb_wr(ADDR_CTRL, cmd(5'd5, 3'b010));
			ahb_rd(ADDR_IRQ_STAT, r);
			`CHK(r, (k <= 8) ? 32'h1 : 32'h0)
			ahb_rd(ADDR_CTRL, r);
			`CHK(r, ctl(k, 1'b1, 5'd5))
		end
		// Keyed write with no operation bit only moves the selected address
		ahb_wr(ADDR_CTRL, cmd(5'd9, 3'b000));
		ahb_rd(ADDR_CTRL, r);
		`CHK(r, ctl(0, 1'b1, 5'd9))
		// Single load returns what was stored
		lq.delete();
		ahb_wr(ADDR_CTRL, cmd(5'd5, 3'b001));
		repeat (3) @(posedge clk);
		`CHK(lq.size(), 1)
		`CHK(lq[0], {5'd5, 16'h3c05})
		// General load with a junk address restores every stored place
		ahb_wr(ADDR_CTRL, cmd(5'd2, 3'b010));
		lq.delete();
		ahb_wr(ADDR_CTRL, cmd(5'd31, 3'b100));
		@(posedge clk);
		`CHK(busy, 1'b1)
		// Five frozen edges must stretch the walk by exactly five cycles
		ce <= 1'b0;
		repeat (5) @(posedge clk);
		`CHK(busy, 1'b1)
		ce <= 1'b1;
		for (k = 0; k < 100 && busy !== 1'b0; k++) begin
			@(posedge clk);
		end
		`CHK(k, 32)
		`CHK(busy, 1'b0)
		repeat (2) @(posedge clk);
		`CHK(lq.size(), 2)
		`CHK(lq[0], {5'd2, 16'h3c02})
		`CHK(lq[1], {5'd5, 16'h3c05})
		// Reset in mid-run clears the control word and events; the count read is of never-stored location 0
		`CHK(irq, 1'b1)
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHK(irq, 1'b0)
		ahb_rd(ADDR_CTRL, r);
		`CHK(r, ctl(0, 1'b1, 5'd0))
		give_verdict();
	end
endmodule // nvm_access_tb
